/* design/sib_blinker.sv */
// top: two status indicator channels behind an ahb-lite register slave
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/100ps
module sib_blinker
  import sib_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = sib_pkg::TICK_CYCLES_DEF
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [sib_pkg::DATA_W-1:0] hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout,
  output logic                            hresp,
  output logic [sib_pkg::DATA_W-1:0]      hrdata,
  input  wire logic                       power_state_ind,
  input  wire logic                       otp_prog_done,
  input  wire logic                       otp_prog_error,
  output logic                            ind1_lamp,
  output logic                            ind2_lamp
);

  import sib_pkg::*;

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic [CTRL_W-1:0]     ctrl_r [2];
  logic                  wr_pend_r;
  logic [IDX_W-1:0]      wr_idx_r;
  logic [1:0]            restart_r;
  logic [DATA_W-1:0]     hrdata_r;
  logic                  hreadyout_r;
  logic                  hresp_r;
  logic [TICK_CNT_W-1:0] tick_cnt_r;
  logic                  tick_r;
  logic                  ind1_lamp_r;
  logic                  ind2_lamp_r;
  logic [1:0]            man_on;
  logic [1:0]            seq_done;
  logic                  addr_ok;
  logic [IDX_W-1:0]      addr_idx;
  logic                  take;
  logic [CTRL_W-1:0]     wr_val;

  // field pickers, shared by both channels
  function automatic logic [1:0] fld(input logic [CTRL_W-1:0] v, input int unsigned lsb);
    fld = v[lsb +: 2];
  endfunction

  // source selection; reserved code treated as off
  function automatic logic drive(input logic [1:0] src, input logic pwr, input logic man);
    unique case (src)
      SRC_OFF:    drive = 1'b0;
      SRC_POWER:  drive = pwr;
      SRC_RSVD:   drive = 1'b0;
      SRC_MANUAL: drive = man; // pattern only counts here
    endcase
  endfunction

  // ------------------------------------------------------------------
  // ahb-lite address phase
  // ------------------------------------------------------------------
  assign addr_ok  = (haddr[1:0] == 2'h0);
  assign addr_idx = haddr[31:2];
  assign take     = hsel && hready && htrans[1];
  assign wr_val   = hwdata[CTRL_W-1:0] & CTRL_WR_MASK;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= '0;
    end else begin
      wr_pend_r <= take && hwrite && addr_ok;
      wr_idx_r  <= addr_idx;
    end
  end

  // zero wait states; the slave never errors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // control registers, written in the data phase
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r[0] <= CTRL_RESET;
      ctrl_r[1] <= CTRL_RESET;
      restart_r <= 2'h0;
    end else begin
      restart_r <= 2'h0;
      if (wr_pend_r && wr_idx_r == IND1_CTRL_IDX) begin
        ctrl_r[0]    <= wr_val;
        restart_r[0] <= 1'b1; // any rewrite rearms the pattern
      end
      if (wr_pend_r && wr_idx_r == IND2_CTRL_IDX) begin
        ctrl_r[1]    <= wr_val;
        restart_r[1] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // read data, loaded at the address phase
  // ------------------------------------------------------------------
  // a read right behind a write to the same word sees the new data through wr_val,
  // since the write lands on the very edge that samples the read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
    end else if (take && !hwrite) begin
      hrdata_r <= '0;
      if (addr_ok && addr_idx == IND1_CTRL_IDX) begin
        if (wr_pend_r && wr_idx_r == IND1_CTRL_IDX) begin
          hrdata_r <= {16'h0000, wr_val};
        end else begin
          hrdata_r <= {16'h0000, ctrl_r[0]};
        end
      end
      if (addr_ok && addr_idx == IND2_CTRL_IDX) begin
        if (wr_pend_r && wr_idx_r == IND2_CTRL_IDX) begin
          hrdata_r <= {16'h0000, wr_val};
        end else begin
          hrdata_r <= {16'h0000, ctrl_r[1]};
        end
      end
      if (addr_ok && addr_idx == STATUS_IDX) begin
        hrdata_r <= {28'h0000000, seq_done, ind2_lamp_r, ind1_lamp_r};
      end
    end
  end

  // ------------------------------------------------------------------
  // slow timebase
  // ------------------------------------------------------------------
  // one shared tick; the first on period after a rewrite may lose up
  // to one tick, traded for a single divider
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == TICK_CNT_W'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= TICK_CNT_W'(tick_cnt_r + 1'b1);
      tick_r     <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // channels
  // ------------------------------------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_ch
    sib_channel u_ch (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .tick     (tick_r),
      .restart  (restart_r[c]),
      .pattern  (fld(ctrl_r[c], PAT_LSB)),
      .count    (fld(ctrl_r[c], COUNT_LSB)),
      .on_time  (fld(ctrl_r[c], ONT_LSB)),
      .duty     (fld(ctrl_r[c], DUTY_LSB)),
      .lamp_on  (man_on[c]),
      .seq_done (seq_done[c])
    );
  end

  // ------------------------------------------------------------------
  // lamp drive
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ind1_lamp_r <= 1'b0;
      ind2_lamp_r <= 1'b0;
    end else begin
      ind1_lamp_r <= drive(fld(ctrl_r[0], SRC_LSB), power_state_ind, man_on[0])
                     || otp_prog_done;
      ind2_lamp_r <= drive(fld(ctrl_r[1], SRC_LSB), power_state_ind, man_on[1])
                     || otp_prog_error;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;
  assign hrdata    = hrdata_r;
  assign ind1_lamp = ind1_lamp_r;
  assign ind2_lamp = ind2_lamp_r;

endmodule

/* design/sib_pkg.sv */
// package: register map, field layout and timing constants of the indicator blinker
package sib_pkg;

  // ------------------------------------------------------------------
  // bus and register map
  // ------------------------------------------------------------------
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned IDX_W         = 30;
  localparam logic [29:0] IND1_CTRL_IDX = 30'h0000404c;
  localparam logic [29:0] IND2_CTRL_IDX = 30'h0000404d;
  localparam logic [29:0] STATUS_IDX    = 30'h0000404e;
  localparam int unsigned CTRL_W        = 16;
  localparam logic [15:0] CTRL_RESET    = 16'hc026;
  localparam logic [15:0] CTRL_WR_MASK  = 16'hc33f;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int unsigned SRC_LSB   = 14;
  localparam int unsigned PAT_LSB   = 8;
  localparam int unsigned COUNT_LSB = 4;
  localparam int unsigned ONT_LSB   = 2;
  localparam int unsigned DUTY_LSB  = 0;

  localparam logic [1:0] SRC_OFF    = 2'h0;
  localparam logic [1:0] SRC_POWER  = 2'h1;
  localparam logic [1:0] SRC_RSVD   = 2'h2;
  localparam logic [1:0] SRC_MANUAL = 2'h3;

  localparam logic [1:0] PAT_OFF    = 2'h0;
  localparam logic [1:0] PAT_STEADY = 2'h1;
  localparam logic [1:0] PAT_CONT   = 2'h2;
  localparam logic [1:0] PAT_SEQ    = 2'h3;

  // ------------------------------------------------------------------
  // timing: one tick is the shortest on-time
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam longint      TICK_TIME_PS    = 64'd62500000000;
  localparam int unsigned TICK_CYCLES_DEF = int'(TICK_TIME_PS / CLK_PERIOD_PS);
  localparam int unsigned TICK_CNT_W      = 24;
  localparam int unsigned SPAN_W          = 7;

  typedef enum logic [1:0] {
    SIB_IDLE,
    SIB_ON,
    SIB_OFF,
    SIB_DONE
  } sib_phase_t;

  // on-time in ticks: 1 s, 250 ms, 125 ms, 62.5 ms
  function automatic logic [6:0] sib_on_ticks(input logic [1:0] code);
    unique case (code)
      2'h0: sib_on_ticks = 7'h10;
      2'h1: sib_on_ticks = 7'h04;
      2'h2: sib_on_ticks = 7'h02;
      2'h3: sib_on_ticks = 7'h01;
    endcase
  endfunction

  // off-time in ticks: on-time times 1, 2, 3 or 7
  function automatic logic [6:0] sib_off_ticks(input logic [1:0] ont, input logic [1:0] duty);
    logic [6:0] on_t;
    on_t = sib_on_ticks(ont);
    unique case (duty)
      2'h0: sib_off_ticks = on_t;
      2'h1: sib_off_ticks = 7'(on_t * 2);
      2'h2: sib_off_ticks = 7'(on_t * 3);
      2'h3: sib_off_ticks = 7'(on_t * 7);
    endcase
  endfunction

  // pulses in a finite sequence: 1, 2, 4, 7
  function automatic logic [2:0] sib_pulses(input logic [1:0] code);
    unique case (code)
      2'h0: sib_pulses = 3'h1;
      2'h1: sib_pulses = 3'h2;
      2'h2: sib_pulses = 3'h4;
      2'h3: sib_pulses = 3'h7;
    endcase
  endfunction

endpackage

/* design/sib_channel.sv */
// one indicator channel: manual-mode pattern engine
`timescale 1ns/100ps
module sib_channel
  import sib_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       tick,
  input  wire logic       restart,
  input  wire logic [1:0] pattern,
  input  wire logic [1:0] count,
  input  wire logic [1:0] on_time,
  input  wire logic [1:0] duty,
  output logic            lamp_on,
  output logic            seq_done
);

  sib_phase_t phase_r;
  logic [6:0] span_r;
  logic [2:0] pulses_r;

  // ------------------------------------------------------------------
  // phase sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r  <= SIB_IDLE;
      span_r   <= 7'h00;
      pulses_r <= 3'h0;
    end else if (restart) begin
      pulses_r <= 3'h0;
      if (pattern == PAT_CONT || pattern == PAT_SEQ) begin
        phase_r <= SIB_ON;
        span_r  <= sib_on_ticks(on_time);
      end else begin
        phase_r <= SIB_IDLE;
      end
    end else if (tick) begin
      unique case (phase_r)
        SIB_IDLE: phase_r <= SIB_IDLE;
        SIB_ON: begin
          if (span_r == 7'h01) begin
            phase_r  <= SIB_OFF;
            span_r   <= sib_off_ticks(on_time, duty);
            pulses_r <= 3'(pulses_r + 3'h1);
          end else begin
            span_r <= 7'(span_r - 7'h01);
          end
        end
        SIB_OFF: begin
          if (span_r != 7'h01) begin
            span_r <= 7'(span_r - 7'h01);
          end else if (pattern == PAT_SEQ && pulses_r == sib_pulses(count)) begin
            phase_r <= SIB_DONE;
          end else begin
            phase_r <= SIB_ON;
            span_r  <= sib_on_ticks(on_time);
          end
        end
        SIB_DONE: phase_r <= SIB_DONE; // held dark until rewritten
      endcase
    end
  end

  assign lamp_on  = (pattern == PAT_STEADY) || (phase_r == SIB_ON);
  assign seq_done = (phase_r == SIB_DONE);

endmodule

/* sim/sib_blinker_chk.sv */
// checker: source, override and pattern assertions on the blinker ports
`timescale 1ns/100ps
module sib_blinker_chk
  import sib_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic                       hclk,
  input wire logic                       hresetn,
  input wire logic                       hsel,
  input wire logic [31:0]                haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic [sib_pkg::DATA_W-1:0] hwdata,
  input wire logic                       hready,
  input wire logic                       power_state_ind,
  input wire logic                       otp_prog_done,
  input wire logic                       otp_prog_error,
  input wire logic                       ind1_lamp,
  input wire logic                       ind2_lamp
);
  // ------------------------------------------------------------------
  // shadow control words, rebuilt from bus writes
  // ------------------------------------------------------------------
  logic        wr_r;
  logic [31:0] wa_r;
  logic [15:0] sh1_r;
  logic [15:0] sh2_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      wa_r <= 32'h0;
    end else if (hready) begin
      wr_r <= hsel && htrans[1] && hwrite;
      wa_r <= haddr;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh1_r <= CTRL_RESET;
      sh2_r <= CTRL_RESET;
    end else if (wr_r && hready) begin
      // unused bits carry noise; keep only what the register holds
      if (wa_r == {IND1_CTRL_IDX, 2'h0}) sh1_r <= hwdata[15:0] & CTRL_WR_MASK;
      if (wa_r == {IND2_CTRL_IDX, 2'h0}) sh2_r <= hwdata[15:0] & CTRL_WR_MASK;
    end
  end
  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_SRC1_OFF: assert property (
    $past(sh1_r[15:14] == SRC_OFF && !otp_prog_done) |-> !ind1_lamp)
    else $error("lamp one lit with source off");
  AST_SRC1_PWR: assert property (
    $past(sh1_r[15:14] == SRC_POWER) |-> ind1_lamp == $past(power_state_ind | otp_prog_done))
    else $error("lamp one does not follow power state");
  AST_SRC2_RSVD: assert property (
    $past(sh2_r[15:14] == SRC_RSVD && !otp_prog_error) |-> !ind2_lamp)
    else $error("lamp two lit on reserved source");
  AST_OTP_DONE: assert property (otp_prog_done |=> ind1_lamp)
    else $error("programming done not shown on lamp one");
  AST_OTP_ERR: assert property (otp_prog_error |=> ind2_lamp)
    else $error("programming error not shown on lamp two");
  AST_SRC2_OFF: assert property (
    $past(sh2_r[15:14] == SRC_OFF && !otp_prog_error) |-> !ind2_lamp)
    else $error("pattern acted with source two off");
  AST_STEADY1: assert property (
    (sh1_r[15:14] == SRC_MANUAL && sh1_r[9:8] == PAT_STEADY)[*4] |=> ind1_lamp)
    else $error("steady pattern left lamp one dark");
  AST_DARK2: assert property (
    (sh2_r[15:8] == {SRC_MANUAL, 4'h0, PAT_OFF} && !otp_prog_error)[*4] |=> !ind2_lamp)
    else $error("off pattern lit lamp two");
endmodule
bind sib_blinker sib_blinker_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .power_state_ind, .otp_prog_done, .otp_prog_error, .ind1_lamp, .ind2_lamp);

/* sim/sib_lamp_model.sv */
// lamp model: reports level and length of every finished lit or dark run
`timescale 1ns/100ps
module sib_lamp_model (
  input  wire logic  hclk,
  input  wire logic  lamp,
  output logic       run_evt,
  output logic       run_lvl,
  output logic [15:0] run_len
);
  logic        last_r = 1'b0;
  logic [15:0] cnt_r  = 16'h0;
  // lamp is passive: it only shows what the pin drives
  always @(posedge hclk) begin
    last_r  <= lamp;
    run_evt <= lamp !== last_r;
    run_lvl <= last_r;
    run_len <= cnt_r;
    cnt_r   <= (lamp !== last_r) ? 16'h1 : cnt_r + 16'h1;
  end
endmodule

/* sim/sib_blinker_test.sv */
// testbench: register access and lamp pattern checks of the indicator blinker
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module sib_blinker_test;
  import sib_pkg::*;
  localparam int unsigned TCK = 4;
  localparam logic [31:0] A1  = {IND1_CTRL_IDX, 2'h0};
  localparam logic [31:0] A2  = {IND2_CTRL_IDX, 2'h0};
  localparam int ON_T [4] = '{16, 4, 2, 1};
  localparam int OFF_K [4] = '{1, 2, 3, 7};
  localparam int NP [4] = '{1, 2, 4, 7};
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h8a3f, r;
  logic power_state_ind = 1'b0, otp_prog_done = 1'b0, otp_prog_error = 1'b0;
  logic hreadyout, hresp, ind1_lamp, ind2_lamp, run_evt, run_lvl, ch = 1'b0;
  logic watch = 1'b0, rd_dp = 1'b0;
  logic [31:0] hrdata;
  logic [15:0] run_len;
  logic [16:0] e;
  logic [31:0] rx;
  logic [31:0] rq [$];
  logic [16:0] lq [$];
  int compares = 0, bad_count = 0;
  wire logic hready = hreadyout;
  wire logic lamp_mon = ch ? ind2_lamp : ind1_lamp;
  sib_blinker #(.TICK_CYCLES(TCK)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .power_state_ind,
    .otp_prog_done, .otp_prog_error, .ind1_lamp, .ind2_lamp);
  sib_lamp_model lmp_u (.hclk, .lamp(lamp_mon), .run_evt, .run_lvl, .run_len);
  always #2.5 hclk = ~hclk;
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 100);
    if (k >= 100) begin
      bad_count++;
      wrap_up();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    rq.push_back(x);
    bus(1'b0, a, 32'h0);
  endtask
  // unused bits get noise, read-back must drop it
  task automatic wr(input logic c2, input logic [15:0] f);
    bus(1'b1, c2 ? A2 : A1, (rnd() & 32'hffff3cc0) | {16'h0, f});
    rd(c2 ? A2 : A1, {16'h0, f});
  endtask
  task automatic pulse(input logic c2, input logic [1:0] p, input logic [1:0] c,
                       input logic [1:0] o, input logic [1:0] d);
    int on_c, off_c, n, k;
    on_c = ON_T[o] * TCK;
    off_c = on_c * OFF_K[d];
    n = (p == PAT_SEQ) ? NP[c] : 4;
    watch = 1'b0;
    ch = c2;
    wr(c2, {SRC_MANUAL, 14'h0});
    repeat (20) @(posedge hclk);
    watch = 1'b1;
    lq.push_back(17'h0);
    lq.push_back(17'h10000);
    for (k = 1; k < n; k++) begin
      lq.push_back({1'b0, 16'(off_c)});
      lq.push_back({1'b1, 16'(on_c)});
    end
    wr(c2, {SRC_MANUAL, 4'h0, p, 2'h0, c, o, d});
    for (k = 0; k < 9000 && lq.size() > 0; k++) @(posedge hclk);
    `CHK(lq.size(), 0)
    if (lq.size() > 0) wrap_up();
    lq.delete();
    if (p == PAT_SEQ) repeat (2 * off_c + 20) @(posedge hclk);
    watch = 1'b0;
  endtask
  // ------------------------------------------------------------------
  // result watchers
  // ------------------------------------------------------------------
  always @(posedge hclk) begin
    // pop once: the macro names its operands twice
    if (rd_dp && hreadyout === 1'b1 && rq.size() > 0) begin
      rx = rq.pop_front();
      `CHK({hresp, hrdata}, {1'b0, rx})
    end
    rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
    if (watch && run_evt === 1'b1) begin
      if (lq.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        e = lq.pop_front();
        `CHK(run_lvl, e[16])
        if (e[15:0] != 0 && e[16]) `CHK(run_len, e[15:0])
        if (e[15:0] != 0 && !e[16]) `CHK(run_len, e[15:0])
      end
    end
  end
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(A1, {16'h0, CTRL_RESET});
    rd(A2, {16'h0, CTRL_RESET});
    rd(32'h0001013c, 32'h0);
    rd(A1 | 32'h2, 32'h0);
    for (int s = 0; s < 2; s++) begin
      r = rnd();
      wr(1'b0, {s ? SRC_OFF : SRC_POWER, 4'h0, r[9:8], 8'h0});
      wr(1'b1, {s ? SRC_OFF : SRC_RSVD, 4'h0, r[1:0], 8'h0});
      repeat (60) begin
        {otp_prog_error, otp_prog_done, power_state_ind} <= 3'(rnd());
        @(posedge hclk);
      end
    end
    {otp_prog_error, otp_prog_done, power_state_ind} <= 3'h0;
    wr(1'b0, {SRC_MANUAL, 4'h0, PAT_STEADY, 8'h0});
    wr(1'b1, {SRC_MANUAL, 14'h0});
    repeat (20) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      pulse(i[0], (i < 4) ? PAT_SEQ : PAT_CONT, (i < 4) ? 2'(i) : r[1:0],
            2'(i + i / 4), 2'(3 - i));
    end
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(A2, {16'h0, CTRL_RESET});
    repeat (4) @(posedge hclk);
    wrap_up();
  end
endmodule
